// file: bbox_pkg.sv
// Purpose: Shared constants and carriers for the byte/bit op execute block
// Assumes: 14-bit instruction word, 8-bit data, 7-bit register index
// Notes:   Every field position and opcode value lives here
package bbox_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int POS_W  = 3;
   localparam int INSN_W = 14;

   // Instruction field positions and nibble width
   localparam int CLASS_HI = 13;
   localparam int CLASS_LO = 12;
   localparam int OPC_HI   = 11;
   localparam int OPC_LO   = 8;
   localparam int BOPC_HI  = 11;
   localparam int BOPC_LO  = 10;
   localparam int DEST_BIT = 7;
   localparam int POS_HI   = 9;
   localparam int POS_LO   = 7;
   localparam int REG_HI   = 6;
   localparam int REG_LO   = 0;
   localparam int NIB_W    = 4;

   // Opcode values
   localparam logic [1:0] CLASS_BYTE = 2'h0;
   localparam logic [1:0] CLASS_BIT  = 2'h1;
   localparam logic [3:0] OPC_ADD    = 4'h7;
   localparam logic [3:0] OPC_AND    = 4'h5;
   localparam logic [1:0] BOPC_CLR   = 2'h0;
   localparam logic [1:0] BOPC_TSTZ  = 2'h2;

   // Reset values
   localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
   localparam logic              FLAG_RST = 1'b0;

   typedef struct packed {
      logic              overflow_out_flag;
      logic              nibble_carry;
      logic              result_all_low_flag;
   } bbox_flags_s;

   typedef struct packed {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } bbox_wr_s;

   typedef struct packed {
      logic [DATA_W-1:0] acc;
      bbox_flags_s       flags;
      bbox_wr_s          wr;
      logic              idle_slot;
      logic              skip_taken;
   } bbox_state_s;

endpackage : bbox_pkg

// file: bbox_bit_unit.sv
// Purpose: Select one bit of a byte and form the byte with that bit cleared
// Assumes: Position is always in range for the width
// Notes:   Pure combinational
`timescale 1ns/100ps
module bbox_bit_unit #(
   parameter int WIDTH = 8,
   parameter int POS_W = 3
) (
   // Operand
   input  wire logic [WIDTH-1:0] i_value,
   input  wire logic [POS_W-1:0] i_pos,
   // Results
   output logic                  o_bit,
   output logic [WIDTH-1:0]      o_cleared
);

   logic [WIDTH-1:0] mask;

   always_comb begin
      mask      = {{(WIDTH-1){1'b0}}, 1'b1} << i_pos;
      o_bit     = |(i_value & mask);
      o_cleared = i_value & ~mask;
   end

endmodule : bbox_bit_unit

// file: bbox_execute.sv
// Purpose: Execute add, AND, bit clear and bit test-skip for an 8-bit core
// Assumes: Register file reads combinationally from o_rf_raddr
// Notes:   Own write-back is forwarded to cover the registered write delay
//
// Overview of operation
// RULE1: Add accumulator to register, update three flags
// RULE2: Destination bit 0 accumulator, 1 register
// RULE3: AND accumulator with register, only zero flag
// RULE4: Test bit, skip next when bit low
// RULE5: Skipped prefetch replaced by an idle slot
// RULE6: Test takes one cycle, two when skipping
// RULE7: Clear selected register bit, flags untouched
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module bbox_execute
   import bbox_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   input  wire logic              i_ce,
   // Instruction from decoder
   input  wire logic              i_insn_valid,
   input  wire logic [INSN_W-1:0] i_insn,
   // Accumulator load from the rest of the core
   input  wire logic              i_acc_load,
   input  wire logic [DATA_W-1:0] i_acc_data,
   // Register file read
   output logic [ADDR_W-1:0]      o_rf_raddr,
   input  wire logic [DATA_W-1:0] i_rf_rdata,
   // Register file write
   output logic                   o_rf_we,
   output logic [ADDR_W-1:0]      o_rf_waddr,
   output logic [DATA_W-1:0]      o_rf_wdata,
   // Core state
   output logic [DATA_W-1:0]      o_acc,
   output bbox_flags_s            o_flags,
   output logic                   o_idle_slot,
   output logic                   o_skip_taken,
   output logic                   o_insn_accept
);

   bbox_state_s q;
   bbox_state_s d;

   logic              is_byte;
   logic              is_bit;
   logic              op_add;
   logic              op_and;
   logic              op_clr;
   logic              op_tst;
   logic              dest_reg;
   logic [ADDR_W-1:0] reg_idx;
   logic [POS_W-1:0]  bit_pos;
   logic [DATA_W-1:0] operand;
   logic [DATA_W:0]   sum;
   logic [NIB_W:0]    nib_sum;
   logic [DATA_W-1:0] result;
   logic              sel_bit;
   logic [DATA_W-1:0] cleared;
   logic              exec;

   assign reg_idx    = i_insn[REG_HI:REG_LO];
   assign bit_pos    = i_insn[POS_HI:POS_LO];
   assign dest_reg   = i_insn[DEST_BIT];
   assign is_byte    = i_insn[CLASS_HI:CLASS_LO] == CLASS_BYTE;
   assign is_bit     = i_insn[CLASS_HI:CLASS_LO] == CLASS_BIT;
   assign op_add     = is_byte && i_insn[OPC_HI:OPC_LO] == OPC_ADD;
   assign op_and     = is_byte && i_insn[OPC_HI:OPC_LO] == OPC_AND;
   assign op_clr     = is_bit && i_insn[BOPC_HI:BOPC_LO] == BOPC_CLR;
   assign op_tst     = is_bit && i_insn[BOPC_HI:BOPC_LO] == BOPC_TSTZ;
   assign o_rf_raddr = reg_idx;

   // Prefetched word is thrown away while the idle slot runs
   assign exec          = i_insn_valid && !q.idle_slot; // RULE5
   assign o_insn_accept = i_ce && i_insn_valid;

   // Last write not yet in the file; forward it to a back-to-back reader
   assign operand = (q.wr.we && q.wr.addr == reg_idx) ? q.wr.data
                                                     : i_rf_rdata;

   assign sum     = {1'b0, q.acc} + {1'b0, operand};
   assign nib_sum = {1'b0, q.acc[NIB_W-1:0]} + {1'b0, operand[NIB_W-1:0]};

   bbox_bit_unit #(
      .WIDTH (DATA_W),
      .POS_W (POS_W)
   ) u_bit (
      .i_value   (operand),
      .i_pos     (bit_pos),
      .o_bit     (sel_bit),
      .o_cleared (cleared)
   );

   always_comb begin
      d           = q;
      d.wr.we     = 1'b0;
      d.skip_taken = 1'b0;
      // Idle slot lasts exactly one cycle
      d.idle_slot = 1'b0; // RULE6
      result      = op_add ? sum[DATA_W-1:0] : (q.acc & operand);
      if (i_acc_load) begin
         d.acc = i_acc_data;
      end
      if (exec) begin
         if (op_add || op_and) begin
            if (dest_reg) begin // RULE2
               d.wr.we   = 1'b1;
               d.wr.addr = reg_idx;
               d.wr.data = result;
            end else begin
               d.acc = result; // RULE2
            end
            d.flags.result_all_low_flag = result == '0; // RULE1 RULE3
            if (op_add) begin
               d.flags.overflow_out_flag = sum[DATA_W]; // RULE1
               d.flags.nibble_carry      = nib_sum[NIB_W]; // RULE1
            end
         end
         if (op_clr) begin
            d.wr.we   = 1'b1; // RULE7
            d.wr.addr = reg_idx;
            d.wr.data = cleared;
         end
         if (op_tst && !sel_bit) begin
            d.idle_slot  = 1'b1; // RULE4 RULE5 RULE6
            d.skip_taken = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         q.acc       <= ACC_RST;
         q.flags     <= '{FLAG_RST, FLAG_RST, FLAG_RST};
         q.wr        <= '0;
         q.idle_slot <= 1'b0;
         q.skip_taken <= 1'b0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_acc        = q.acc;
   assign o_flags      = q.flags;
   assign o_rf_we      = q.wr.we;
   assign o_rf_waddr   = q.wr.addr;
   assign o_rf_wdata   = q.wr.data;
   assign o_idle_slot  = q.idle_slot;
   assign o_skip_taken = q.skip_taken;

endmodule : bbox_execute

// file: bbox_execute_sva.sv
// Purpose: Port assertions for the execute block
// Assumes: Operand forwarded from own pending write-back
// Notes:   Bound into every instance
`timescale 1ns/100ps
module bbox_execute_chk
   import bbox_pkg::*;
(
   // Clock, reset, enable
   input wire logic              i_clk,
   input wire logic              i_reset,
   input wire logic              i_ce,
   // Instruction and accumulator load
   input wire logic              i_insn_valid,
   input wire logic [INSN_W-1:0] i_insn,
   input wire logic              i_acc_load,
   input wire logic [DATA_W-1:0] i_acc_data,
   // Register file
   input wire logic [ADDR_W-1:0] o_rf_raddr,
   input wire logic [DATA_W-1:0] i_rf_rdata,
   input wire logic              o_rf_we,
   input wire logic [ADDR_W-1:0] o_rf_waddr,
   input wire logic [DATA_W-1:0] o_rf_wdata,
   // Core state
   input wire logic [DATA_W-1:0] o_acc,
   input wire bbox_flags_s       o_flags,
   input wire logic              o_idle_slot,
   input wire logic              o_skip_taken,
   input wire logic              o_insn_accept
);
   wire       tk = i_ce & i_insn_valid & ~o_idle_slot;
   wire       fw = o_rf_we && o_rf_waddr == o_rf_raddr;
   wire [7:0] f  = fw ? o_rf_wdata : i_rf_rdata;
   wire [8:0] s  = {1'b0, o_acc} + {1'b0, f};
   wire [4:0] n  = {1'b0, o_acc[3:0]} + {1'b0, f[3:0]};
   wire [2:0] p  = i_insn[POS_HI:POS_LO];
   wire       ad = tk && i_insn[13:8] == {CLASS_BYTE, OPC_ADD};
   wire       an = tk && i_insn[13:8] == {CLASS_BYTE, OPC_AND};
   wire       cl = tk && i_insn[13:10] == {CLASS_BIT, BOPC_CLR};
   wire       ts = tk && i_insn[13:10] == {CLASS_BIT, BOPC_TSTZ};
   wire [7:0] r  = ad ? s[7:0] : (o_acc & f);
   wire       d  = i_insn[DEST_BIT];
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   add_flags_a: assert property (ad |=> o_flags ==
      $past({s[8], n[4], s[7:0] == 8'h00})) else $error("add flags");
   and_zero_a: assert property (an |=> o_flags ==
      {$past(o_flags[2:1]), $past(r == 8'h00)}) else $error("and flags");
   dest_acc_a: assert property ((ad || an) && !d |=>
      o_acc == $past(r) && !o_rf_we) else $error("acc dest");
   dest_reg_a: assert property ((ad || an) && d |=> o_rf_we &&
      {o_rf_waddr, o_rf_wdata} == $past({i_insn[6:0], r}))
      else $error("reg dest");
   skip_low_a: assert property (ts && !f[p] |=> o_idle_slot &&
      o_skip_taken && $stable(o_flags)) else $error("no skip");
   no_skip_a: assert property (ts && f[p] |=> !o_idle_slot &&
      $stable(o_flags)) else $error("false skip");
   skip_once_a: assert property (o_idle_slot && i_ce |=>
      !o_idle_slot) else $error("long idle");
   clr_bit_a: assert property (cl |=> o_rf_we && $stable(o_flags) &&
      o_rf_wdata == $past(f & ~(8'h01 << p))) else $error("bit clear");
   cover property (ad && d);
   cover property (ts && !f[p]);
   cover property (cl && fw);
endmodule : bbox_execute_chk
bind bbox_execute bbox_execute_chk bbox_execute_chk_i (.*);

// file: tb.sv
// Purpose: Directed tests of the execute block
// Assumes: Register file modelled here as a plain array
// Notes:   Clock enable dropped once to check that state freezes
`timescale 1ns/100ps
module tb
   import bbox_pkg::*;
;
   logic i_clk = 1'b0, i_reset = 1'b1, i_ce = 1'b1;
   logic i_insn_valid = 1'b0, i_acc_load = 1'b0;
   logic [INSN_W-1:0] i_insn = '0;
   logic [DATA_W-1:0] i_acc_data = '0, i_rf_rdata, o_rf_wdata, o_acc;
   logic [ADDR_W-1:0] o_rf_raddr, o_rf_waddr;
   logic o_rf_we, o_idle_slot, o_skip_taken, o_insn_accept;
   bbox_flags_s o_flags;
   logic [7:0] rf [128];
   int errors = 0, checks_done = 0;
   always #20 i_clk = ~i_clk;
   assign i_rf_rdata = rf[o_rf_raddr];
   always @(posedge i_clk) if (o_rf_we) rf[o_rf_waddr] <= o_rf_wdata;
   bbox_execute bbox_execute_i (
      .i_clk         (i_clk),
      .i_reset       (i_reset),
      .i_ce          (i_ce),
      .i_insn_valid  (i_insn_valid),
      .i_insn        (i_insn),
      .i_acc_load    (i_acc_load),
      .i_acc_data    (i_acc_data),
      .o_rf_raddr    (o_rf_raddr),
      .i_rf_rdata    (i_rf_rdata),
      .o_rf_we       (o_rf_we),
      .o_rf_waddr    (o_rf_waddr),
      .o_rf_wdata    (o_rf_wdata),
      .o_acc         (o_acc),
      .o_flags       (o_flags),
      .o_idle_slot   (o_idle_slot),
      .o_skip_taken  (o_skip_taken),
      .o_insn_accept (o_insn_accept)
   );
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Bits 9:8 of x carry the upper bit position of bit operations
   task automatic op(input logic [1:0] c, input logic [3:0] o, input int x);
      @(posedge i_clk);
      i_acc_load   <= 1'b0;
      i_insn       <= {c, o | 4'(x >> 8), 8'(x)};
      i_insn_valid <= 1'b1;
   endtask : op
   task automatic idle();
      @(posedge i_clk);
      i_insn_valid <= 1'b0;
      #1;
   endtask : idle
   task automatic t_add();
      @(posedge i_clk);
      i_acc_load <= 1'b1;
      i_acc_data <= 8'h17;
      op(CLASS_BYTE, OPC_ADD, 'h005);
      op(CLASS_BYTE, OPC_ADD, 'h086);
      idle();
      chk(o_acc, 8'hd9);
      chk(o_flags, 8'h07);
      chk({o_rf_we, o_rf_waddr}, 8'h86);
      $display("add test done");
   endtask : t_add
   task automatic t_and();
      op(CLASS_BYTE, OPC_AND, 'h005);
      idle();
      chk(o_flags, 8'h06);
      op(CLASS_BYTE, OPC_AND, 'h087);
      idle();
      chk(o_flags, 8'h07);
      chk(o_acc, 8'hc0);
      $display("and test done");
   endtask : t_and
   task automatic t_bit();
      op(CLASS_BIT, {BOPC_CLR, 2'h0}, 'h388);
      op(CLASS_BIT, {BOPC_TSTZ, 2'h0}, 'h388);
      op(CLASS_BYTE, OPC_ADD, 'h005);
      #1;
      chk({o_idle_slot, o_skip_taken}, 8'h03);
      idle();
      chk(o_acc, 8'hc0);
      chk(rf[8], 8'h47);
      op(CLASS_BIT, {BOPC_TSTZ, 2'h0}, 'h008);
      idle();
      chk(o_idle_slot, 8'h00);
      chk(o_flags, 8'h07);
      $display("bit test done");
   endtask : t_bit
   // Carry alone, then nibble carry alone, the second across a freeze
   task automatic t_flags();
      op(CLASS_BYTE, OPC_ADD, 'h005);
      #1;
      chk(o_insn_accept, 8'h01);
      idle();
      chk(o_acc, 8'h82);
      chk(o_flags, 8'h04);
      @(posedge i_clk);
      i_ce <= 1'b0;
      op(CLASS_BYTE, OPC_ADD, 'h009);
      #1;
      chk(o_insn_accept, 8'h00);
      repeat (2) @(posedge i_clk);
      #1;
      chk(o_acc, 8'h82);
      chk(o_flags, 8'h04);
      @(posedge i_clk);
      i_ce <= 1'b1;
      idle();
      chk(o_acc, 8'h90);
      chk(o_flags, 8'h02);
      $display("flag test done");
   endtask : t_flags
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      foreach (rf[k]) rf[k] = 8'h00;
      rf[5] = 8'hc2;
      rf[6] = 8'h27;
      rf[8] = 8'hc7;
      rf[9] = 8'h0e;
      repeat (20) @(posedge i_clk);
      i_reset <= 1'b0;
      t_add();
      t_and();
      t_bit();
      t_flags();
      print_verdict();
   end
   initial begin
      #20000;
      errors++;
      print_verdict();
   end
endmodule : tb
